// ### quad_decoder.sv
module quad_decoder
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // phase inputs and sub-mode
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic [1:0] sub_mode,
  // count steps
  output logic step_up,
  output logic step_dn
);
  logic prev_a;
  logic prev_b;
  logic a_r, a_f, b_r, b_f;

  // previous phase levels for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= phase_a;
      prev_b <= phase_b;
    end
  end

  // four sub-modes, each with its own edge and level conditions
  always_comb begin
    a_r = phase_a & ~prev_a;
    a_f = ~phase_a & prev_a;
    b_r = phase_b & ~prev_b;
    b_f = ~phase_b & prev_b;
    case (sub_mode)
      QUAD_M1: begin
        step_up = (b_r & phase_a) | (b_f & ~phase_a) | (a_r & ~phase_b) | (a_f & phase_b);
        step_dn = (b_f & phase_a) | (b_r & ~phase_a) | (a_r & phase_b) | (a_f & ~phase_b);
      end
      QUAD_M2: begin
        step_up = a_f & phase_b;
        step_dn = a_f & ~phase_b;
      end
      QUAD_M3: begin
        step_up = a_f & phase_b;
        step_dn = b_f & phase_a;
      end
      default: begin
        step_up = (b_r & phase_a) | (b_f & ~phase_a);
        step_dn = (b_f & phase_a) | (b_r & ~phase_a);
      end
    endcase
  end
endmodule

// ### quad_encoder.sv
module quad_encoder #(
  parameter int HOLD = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // step request from the bench
  input wire logic start,
  input wire logic up,
  input wire logic [3:0] steps,
  // encoder phases
  output logic phase_a,
  output logic phase_b,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pos;
  logic [3:0] left;
  logic [3:0] gap;
  // walk the gray position one quarter cycle every HOLD clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 2'h0;
      left <= 4'h0;
      gap <= 4'h0;
    end else if (left == 4'h0) begin
      left <= start ? steps : 4'h0;
      gap <= 4'h0;
    end else if (gap == 4'(HOLD - 1)) begin
      gap <= 4'h0;
      left <= left - 4'h1;
      pos <= up ? pos + 2'h1 : pos - 2'h1;
    end else begin
      gap <= gap + 4'h1;
    end
  end
  // phase a leads b when walking up; one phase changes per step
  assign phase_a = pos[1] ^ pos[0];
  assign phase_b = pos[1];
  assign busy = left != 4'h0;
endmodule

// ### timer_buffer_cascade_pwm_phase_bench.sv
module timer_buffer_cascade_pwm_phase_bench import timer_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0][3:0] match_pin_in = '0;
  logic [NUM_CH-1:0][3:0] match_pin_out;
  logic [NUM_CH-1:0][3:0] match_pin_oe;
  logic [NUM_CH-1:0] irq_req;
  logic q_start = 1'b0;
  logic q_up = 1'b0;
  logic [3:0] q_steps = '0;
  logic pa;
  logic pb;
  logic q_busy;
  ext_clk_t ext_clock_in;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rdata;
  logic rerr;
  logic [31:0] sub_exp [4] = '{32'h4, 32'h1, 32'h1, 32'h2};
  // encoder phases feed both pin pairs
  assign ext_clock_in = {pb, pa, pb, pa};
  timer_unit dut (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in(ext_clock_in), .match_pin_in(match_pin_in), .match_pin_out(match_pin_out),
    .match_pin_oe(match_pin_oe), .irq_req(irq_req));
  quad_encoder enc (.clock(clock), .rst_n(rst_n), .start(q_start), .up(q_up), .steps(q_steps),
    .phase_a(pa), .phase_b(pb), .busy(q_busy));
  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready, then release
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [2:0] ch, input logic [3:0] off, input logic [31:0] d);
    apb({3'h0, ch, off, 2'h0}, 1'b1, d);
  endtask
  task automatic rdc(input logic [2:0] ch, input logic [3:0] off, input logic [31:0] exp);
    apb({3'h0, ch, off, 2'h0}, 1'b0, 32'h0000_0000);
    check(rdata, exp);
  endtask
  // walk the encoder and let the count settle
  task automatic quad(input logic up, input logic [3:0] n);
    q_up <= up;
    q_steps <= n;
    q_start <= 1'b1;
    @(posedge clock);
    q_start <= 1'b0;
    @(posedge clock);
    while (q_busy !== 1'b0) @(posedge clock);
    repeat (6) @(posedge clock);
  endtask
  // high cycles of pin a of one channel over eighty clocks
  task automatic duty(input logic [2:0] ch, input logic [31:0] exp);
    logic [31:0] hi;
    hi = '0;
    repeat (80) begin
      @(negedge clock);
      hi = hi + match_pin_out[ch][0];
    end
    check(hi, exp);
    @(posedge clock);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // reset direction and an unmapped word
    rdc(3'd1, OFF_STAT, 32'h0000_0040);
    rdc(3'd0, 4'ha, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    // buffered compare with overflow interrupt on channel 0
    wr(3'd0, OFF_CNT, 32'h0000_fff0);
    wr(3'd0, OFF_GRA, 32'h0000_fff5);
    wr(3'd0, OFF_GRA + 4'h2, 32'h0000_0009);
    wr(3'd0, OFF_IEN, 32'h0000_0010);
    wr(3'd0, OFF_CTRL, 32'h0000_0800);
    apb(START_ADDR, 1'b1, 32'h0000_0001);
    repeat (40) @(posedge clock);
    check({31'h0, irq_req[0]}, 32'h0000_0001);
    apb(START_ADDR, 1'b1, 32'h0000_0000);
    rdc(3'd0, OFF_GRA, 32'h0000_0009);
    // registers b and d hold zero, so they match once the count wraps
    rdc(3'd0, OFF_STAT, 32'h0000_005f);
    wr(3'd0, OFF_STAT, 32'h0000_0011);
    check({31'h0, irq_req[0]}, 32'h0000_0000);
    // buffered capture on channel 3 with the counter held
    wr(3'd3, OFF_CTRL, 32'h0000_0800);
    wr(3'd3, OFF_IO, 32'h0000_0009);
    wr(3'd3, OFF_GRA, 32'h0000_1234);
    wr(3'd3, OFF_CNT, 32'h0000_0777);
    match_pin_in[3][0] <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(3'd3, OFF_GRA, 32'h0000_0777);
    rdc(3'd3, OFF_GRA + 4'h2, 32'h0000_1234);
    // pwm mode 1 on channel 1: period a, duty b
    wr(3'd1, OFF_GRA, 32'h0000_0007);
    wr(3'd1, OFF_GRA + 4'h1, 32'h0000_0003);
    wr(3'd1, OFF_IO, 32'h0000_0025);
    wr(3'd1, OFF_CTRL, 32'h0000_0220);
    check({31'h0, match_pin_out[1][0]}, 32'h0000_0001);
    check({31'h0, match_pin_oe[1][1]}, 32'h0000_0000);
    apb(START_ADDR, 1'b1, 32'h0000_0002);
    // seven high counts before the first period ends, then four of every eight
    duty(3'd1, 32'd43);
    apb(START_ADDR, 1'b1, 32'h0000_0000);
    wr(3'd1, OFF_GRA + 4'h1, 32'h0000_0007);
    wr(3'd1, OFF_CNT, 32'h0000_0000);
    apb(START_ADDR, 1'b1, 32'h0000_0002);
    duty(3'd1, 32'd80);
    apb(START_ADDR, 1'b1, 32'h0000_0000);
    // pwm mode 2 on channel 0: d sets the cycle, a the duty, b equals the cycle
    wr(3'd0, OFF_GRA, 32'h0000_0003);
    wr(3'd0, OFF_GRA + 4'h1, 32'h0000_0007);
    wr(3'd0, OFF_GRA + 4'h3, 32'h0000_0007);
    wr(3'd0, OFF_IO, 32'h0000_0052);
    wr(3'd0, OFF_CNT, 32'h0000_0000);
    wr(3'd0, OFF_CTRL, 32'h0000_0380);
    check({31'h0, match_pin_oe[0][3]}, 32'h0000_0000);
    apb(START_ADDR, 1'b1, 32'h0000_0001);
    duty(3'd0, 32'd40);
    check({31'h0, match_pin_out[0][1]}, 32'h0000_0001);
    apb(START_ADDR, 1'b1, 32'h0000_0000);
    // channel 2 in quadrature under cascaded channel 1
    wr(3'd2, OFF_CTRL, 32'h0000_0400);
    wr(3'd1, OFF_CTRL, 32'h0000_0007);
    wr(3'd2, OFF_CNT, 32'h0000_fffe);
    wr(3'd1, OFF_CNT, 32'h0000_0000);
    apb(START_ADDR, 1'b1, 32'h0000_0006);
    quad(1'b1, 4'd4);
    rdc(3'd2, OFF_CNT, 32'h0000_0002);
    rdc(3'd1, OFF_CNT, 32'h0000_0001);
    rdc(3'd2, OFF_STAT, 32'h0000_0053);
    wr(3'd2, OFF_STAT, 32'h0000_0010);
    quad(1'b0, 4'd4);
    rdc(3'd2, OFF_CNT, 32'h0000_fffe);
    rdc(3'd1, OFF_CNT, 32'h0000_0000);
    rdc(3'd2, OFF_STAT, 32'h0000_0023);
    // quadrature on channel 1 itself overrides its cascade choice
    wr(3'd1, OFF_CTRL, 32'h0000_0407);
    quad(1'b1, 4'd4);
    rdc(3'd1, OFF_CNT, 32'h0000_0004);
    // every sub-mode on channel 5, prescaler and edge fields set
    apb(START_ADDR, 1'b1, 32'h0000_0020);
    for (int m = 0; m < 4; m++) begin
      wr(3'd5, OFF_CTRL, 32'((4 + m) * 256 + 27));
      wr(3'd5, OFF_CNT, 32'h0000_0000);
      quad(1'b1, 4'd4);
      rdc(3'd5, OFF_CNT, sub_exp[m]);
    end
    report_and_stop();
  end
endmodule

// ### timer_pkg.sv
package timer_pkg;
  // channel count and counter width
  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  // address fields: channel in bits 8:6, word index in bits 5:2
  localparam int CH_LSB = 6;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_IO = 4'h1;
  localparam logic [3:0] OFF_IEN = 4'h2;
  localparam logic [3:0] OFF_STAT = 4'h3;
  localparam logic [3:0] OFF_CNT = 4'h4;
  localparam logic [3:0] OFF_GRA = 4'h5;
  localparam logic [3:0] OFF_LAST = 4'h8;
  localparam logic [11:0] START_ADDR = 12'h180;
  // counter limits
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // prescaler sources
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [2:0] PSC_EXT_A = 3'h4;
  localparam logic [2:0] PSC_EXT_B = 3'h5;
  localparam logic [2:0] PSC_EXT_C = 3'h6;
  localparam logic [2:0] PSC_CASCADE = 3'h7;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;
  // clear sources: CLR_A plus register index
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_D = 3'h4;
  // channel modes; bit 2 set means quadrature, low bits pick the sub-mode
  localparam logic [2:0] MODE_PWM1 = 3'h2;
  localparam logic [2:0] MODE_PWM2 = 3'h3;
  localparam int MODE_QUAD_BIT = 2;
  localparam logic [1:0] QUAD_M1 = 2'h0;
  localparam logic [1:0] QUAD_M2 = 2'h1;
  localparam logic [1:0] QUAD_M3 = 2'h2;
  // compare actions and capture edges
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // status and enable bit positions (0..3 are registers a..d)
  localparam int ST_OV = 4;
  localparam int ST_UN = 5;
  localparam int ST_DIR = 6;
  // channel capabilities, one bit per channel
  localparam logic [5:0] QUAD_CH = 6'h36;
  localparam logic [5:0] BUF_CH = 6'h09;
  localparam logic [5:0] UPPER_CH = 6'h12;
  // timer_control_reg layout
  typedef struct packed {
    logic buf_b;
    logic buf_a;
    logic [2:0] mode;
    logic [2:0] clear_source_select;
    logic clock_edge_select_hi;
    logic clock_edge_select_lo;
    logic [2:0] prescaler_select;
  } ctrl_t;
  // one nibble of pin_io_control_reg
  typedef struct packed {
    logic capture;
    logic init_level;
    logic [1:0] act;
  } io_t;
  // external clock pins
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } ext_clk_t;
  // reset values
  localparam ctrl_t CTRL_RESET = '0;
  localparam logic [15:0] IO_RESET = 16'h0000;
  localparam logic [5:0] FLAG_RESET = 6'h00;
  localparam logic DIR_RESET = 1'b1;
endpackage

// ### timer_unit.sv
// Overview of operation
// - channels 0 and 3 may buffer register a through c and b through d.
// - buffered compare match copies the buffer into its general register.
// - buffered capture loads the count and moves the old value to the buffer.
// - channels 1 over 2 and 4 over 5 cascade into one 32-bit counter.
// - cascade prescaler choice makes the upper count only on lower wrap events.
// - the lower half underflows only when it counts in quadrature mode.
// - quadrature mode on channel 1 or 4 overrides its cascade selection.
// - cascaded upper increments on lower overflow and decrements on lower underflow.
// - pwm matches set low, high or toggle; duty spans 0 to 100 percent.
// - pwm mode per channel; the clearing register sets the period.
// - pwm mode 1 drives pins a and c from pairs a/b and c/d.
// - pwm mode 1 initial level comes from the a or c setting.
// - pwm mode 1 equal pair values leave the output unchanged.
// - pwm mode 1 gives at most eight outputs over all channels.
// - pwm mode 2 cycle register has no output; clear restores initial levels.
// - pwm mode 2 duty equal to cycle leaves that output unchanged.
// - pwm mode 2 gives at most ten outputs over all channels.
// - channels 1, 2, 4 and 5 can count up and down from two phases.
// - quadrature ignores prescaler and edge choice; clear, capture, compare still work.
// - quadrature wrap sets overflow counting up and underflow counting down.
// - a readable flag shows the current counting direction.
// - channels 1 and 5 use clock pins a/b, channels 2 and 4 use c/d.
// - four quadrature sub-modes with distinct count conditions.
// - a set flag with its enable requests an interrupt until cleared.
// - counting up wraps from maximum to zero and continues.
module timer_unit
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external count clocks and quadrature phases
  input wire ext_clk_t ext_clock_in,
  // capture/compare pins, index is channel then register a..d
  input wire logic [NUM_CH-1:0][3:0] match_pin_in,
  output logic [NUM_CH-1:0][3:0] match_pin_out,
  output logic [NUM_CH-1:0][3:0] match_pin_oe,
  // per-channel interrupt requests
  output logic [NUM_CH-1:0] irq_req
);
  logic rst_meta;
  logic rst_sync_n;
  logic wr_en;
  logic [2:0] wr_ch;
  logic [3:0] wr_off;
  logic [31:0] rd_val;
  logic [5:0] psc_cnt;
  ext_clk_t ext_prev;
  logic [3:0] ext_rise;
  logic [3:0] ext_fall;
  logic [NUM_CH-1:0] start;
  ctrl_t ctrl [NUM_CH];
  io_t [3:0] io [NUM_CH];
  logic [5:0] ien [NUM_CH];
  logic [5:0] flag [NUM_CH];
  logic dir [NUM_CH];
  logic [15:0] cnt [NUM_CH];
  logic [15:0] gr [NUM_CH][4];
  logic [3:0] pin_lvl [NUM_CH];
  logic [3:0] pin_en [NUM_CH];
  logic ov_ev [NUM_CH];
  logic un_ev [NUM_CH];

  // legal register address: word aligned inside a channel, or the start register
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == START_ADDR) || ((a[11:CH_LSB] < 6'(NUM_CH)) && (a[5:2] <= OFF_LAST) && (a[1:0] == 2'b00));
  endfunction

  // one compare action applied to the current pin level
  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    case (act)
      ACT_NONE: apply_act = cur;
      ACT_LOW: apply_act = 1'b0;
      ACT_HIGH: apply_act = 1'b1;
      default: apply_act = ~cur;
    endcase
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // apb decode; zero wait states, error on unmapped addresses
  assign wr_en = psel && penable && pwrite && addr_ok(paddr);
  assign wr_ch = paddr[8:6];
  assign wr_off = paddr[5:2];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr == START_ADDR) begin
      rd_val[5:0] = start;
    end else if (addr_ok(paddr)) begin
      case (wr_off)
        OFF_CTRL: rd_val[12:0] = ctrl[wr_ch];
        OFF_IO: rd_val[15:0] = io[wr_ch];
        OFF_IEN: rd_val[5:0] = ien[wr_ch];
        OFF_STAT: rd_val[6:0] = {dir[wr_ch], flag[wr_ch]};
        OFF_CNT: rd_val[15:0] = cnt[wr_ch];
        default: rd_val[15:0] = gr[wr_ch][2'(wr_off - OFF_GRA)];
      endcase
    end
  end

  // read data captured in the setup cycle, held through the access phase
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_val;
    end
  end

  // count start register
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start <= 6'h00;
    end else if (wr_en && paddr == START_ADDR) begin
      start <= pwdata[5:0];
    end
  end

  // internal prescaler and external clock edge detection
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      psc_cnt <= 6'h00;
      ext_prev <= '0;
    end else begin
      psc_cnt <= psc_cnt + 6'h01;
      ext_prev <= ext_clock_in;
    end
  end
  assign ext_rise = ext_clock_in & ~ext_prev;
  assign ext_fall = ~ext_clock_in & ext_prev;

  // pins and interrupt requests gathered onto the ports
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      match_pin_out[k] = pin_lvl[k];
      match_pin_oe[k] = pin_en[k];
      irq_req[k] = |(flag[k] & ien[k]);
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic HAS_CD = BUF_CH[i];
    localparam logic IS_UPPER = UPPER_CH[i];
    localparam logic CAN_QUAD = QUAD_CH[i];
    localparam int LO = (i + 1) % NUM_CH;
    logic sw, quad, casc, base_tick, up, dn, tick, clear, cyc_ok, q_up, q_dn;
    logic [1:0] bufd;
    logic [1:0] cyc;
    logic [3:0] match, cap, hit, pin_prev, valid, ext_pick;
    logic [15:0] next_cnt;

    assign sw = wr_en && (wr_ch == 3'(i));
    assign valid = HAS_CD ? 4'hf : 4'h3;
    assign bufd = {ctrl[i].buf_b, ctrl[i].buf_a} & {2{HAS_CD}};

    // channels 1 and 5 use pins a/b, channels 2 and 4 use pins c/d
    quad_decoder u_quad (
      .clock(clock),
      .rst_n(rst_sync_n),
      .phase_a((i == 1 || i == 5) ? ext_clock_in.a : ext_clock_in.c),
      .phase_b((i == 1 || i == 5) ? ext_clock_in.b : ext_clock_in.d),
      .sub_mode(ctrl[i].mode[1:0]),
      .step_up(q_up),
      .step_dn(q_dn)
    );

    // count source selection, match, capture and clear decisions
    always_comb begin
      ext_pick = ctrl[i].clock_edge_select_hi ? (ext_rise | ext_fall) :
                 ctrl[i].clock_edge_select_lo ? ext_fall : ext_rise;
      case (ctrl[i].prescaler_select)
        PSC_DIV1: base_tick = 1'b1;
        PSC_DIV4: base_tick = (psc_cnt & DIV4_MASK) == DIV4_MASK;
        PSC_DIV16: base_tick = (psc_cnt & DIV16_MASK) == DIV16_MASK;
        PSC_DIV64: base_tick = (psc_cnt & DIV64_MASK) == DIV64_MASK;
        PSC_EXT_A: base_tick = ext_pick[0];
        PSC_EXT_B: base_tick = ext_pick[1];
        PSC_EXT_C: base_tick = ext_pick[2];
        default: base_tick = IS_UPPER ? 1'b0 : ext_pick[3];
      endcase
      quad = ctrl[i].mode[MODE_QUAD_BIT] && CAN_QUAD;
      casc = IS_UPPER && (ctrl[i].prescaler_select == PSC_CASCADE) && !quad;
      if (quad) begin
        up = start[i] && q_up;
        dn = start[i] && q_dn;
      end else if (casc) begin
        up = start[i] && ov_ev[LO];
        dn = start[i] && un_ev[LO];
      end else begin
        up = start[i] && base_tick;
        dn = 1'b0;
      end
      tick = up || dn;
      for (int x = 0; x < 4; x++) begin
        match[x] = valid[x] && tick && !io[i][x].capture && (cnt[i] == gr[i][x]);
        cap[x] = valid[x] && io[i][x].capture && (
                 (io[i][x].act[0] && match_pin_in[i][x] && !pin_prev[x]) ||
                 (io[i][x].act[1] && !match_pin_in[i][x] && pin_prev[x]));
      end
      hit = match | cap;
      cyc_ok = (ctrl[i].clear_source_select >= CLR_A) && (ctrl[i].clear_source_select <= CLR_D);
      cyc = 2'(ctrl[i].clear_source_select - CLR_A);
      clear = cyc_ok && hit[cyc];
      if (sw && wr_off == OFF_CNT) begin
        next_cnt = pwdata[15:0];
      end else if (clear) begin
        next_cnt = CNT_ZERO;
      end else if (up) begin
        next_cnt = cnt[i] + 16'h0001;
      end else if (dn) begin
        next_cnt = cnt[i] - 16'h0001;
      end else begin
        next_cnt = cnt[i];
      end
    end
    assign ov_ev[i] = up && (cnt[i] == CNT_MAX);
    assign un_ev[i] = dn && (cnt[i] == CNT_ZERO);

    // pin output enables per mode
    always_comb begin
      for (int x = 0; x < 4; x++) begin
        case (ctrl[i].mode)
          MODE_PWM1: pin_en[i][x] = valid[x] && !io[i][x].capture && (x % 2 == 0);
          MODE_PWM2: pin_en[i][x] = valid[x] && !io[i][x].capture && !(cyc_ok && cyc == 2'(x));
          default: pin_en[i][x] = valid[x] && !io[i][x].capture && (io[i][x].act != ACT_NONE);
        endcase
      end
    end

    // configuration registers
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ctrl[i] <= CTRL_RESET;
        io[i] <= IO_RESET;
        ien[i] <= FLAG_RESET;
      end else if (sw) begin
        if (wr_off == OFF_CTRL) ctrl[i] <= ctrl_t'(pwdata[12:0]);
        if (wr_off == OFF_IO) io[i] <= pwdata[15:0];
        if (wr_off == OFF_IEN) ien[i] <= pwdata[5:0];
      end
    end

    // counter and capture pin history
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cnt[i] <= CNT_ZERO;
        pin_prev <= 4'h0;
      end else begin
        cnt[i] <= next_cnt;
        pin_prev <= match_pin_in[i];
      end
    end

    // general registers with same-cycle buffer transfers
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        for (int x = 0; x < 4; x++) gr[i][x] <= CNT_ZERO;
      end else begin
        for (int x = 0; x < 4; x++) begin
          if (sw && valid[x] && wr_off == OFF_GRA + 4'(x)) begin
            gr[i][x] <= pwdata[15:0];
          end else if (cap[x]) begin
            gr[i][x] <= cnt[i];
          end else if (x >= 2 && bufd[x % 2] && cap[x - 2]) begin
            gr[i][x] <= gr[i][(x + 2) % 4];
          end else if (x < 2 && bufd[x % 2] && match[x]) begin
            gr[i][x] <= gr[i][(x + 2) % 4];
          end
        end
      end
    end

    // status flags: hardware set wins over a write-one clear
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        flag[i] <= FLAG_RESET;
        dir[i] <= DIR_RESET;
      end else begin
        flag[i] <= (flag[i] & ~((sw && wr_off == OFF_STAT) ? pwdata[5:0] : 6'h00)) |
                   {un_ev[i], ov_ev[i], hit};
        if (up) dir[i] <= 1'b1;
        else if (dn) dir[i] <= 1'b0;
      end
    end

    // pin levels for normal, pwm mode 1 and pwm mode 2
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pin_lvl[i] <= 4'h0;
      end else if (!start[i]) begin
        for (int x = 0; x < 4; x++) pin_lvl[i][x] <= io[i][x].init_level;
      end else begin
        case (ctrl[i].mode)
          MODE_PWM1: begin
            for (int p = 0; p < 4; p += 2) begin
              if (gr[i][p] != gr[i][p + 1]) begin
                if (match[p]) pin_lvl[i][p] <= apply_act(pin_lvl[i][p], io[i][p].act);
                else if (match[p + 1]) pin_lvl[i][p] <= apply_act(pin_lvl[i][p], io[i][p + 1].act);
              end
            end
          end
          MODE_PWM2: begin
            for (int x = 0; x < 4; x++) begin
              if (!cyc_ok || gr[i][x] != gr[i][cyc]) begin
                if (clear && match[cyc]) pin_lvl[i][x] <= io[i][x].init_level;
                else if (match[x] && !(cyc_ok && cyc == 2'(x)))
                  pin_lvl[i][x] <= apply_act(pin_lvl[i][x], io[i][x].act);
              end
            end
          end
          default: begin
            for (int x = 0; x < 4; x++) begin
              if (match[x]) pin_lvl[i][x] <= apply_act(pin_lvl[i][x], io[i][x].act);
            end
          end
        endcase
      end
    end

    property p_buf_cmp;
      @(posedge clock) disable iff (!rst_sync_n)
      (match[0] && bufd[0] && !sw) |=> gr[i][0] == $past(gr[i][2]);
    endproperty
    a_buf_cmp: assert property (p_buf_cmp)
      else $error("buffered compare did not reload register a");

    property p_buf_cap;
      @(posedge clock) disable iff (!rst_sync_n)
      (cap[0] && bufd[0] && !sw) |=> (gr[i][0] == $past(cnt[i])) && (gr[i][2] == $past(gr[i][0]));
    endproperty
    a_buf_cap: assert property (p_buf_cap)
      else $error("buffered capture did not shift values");

    property p_ovf;
      @(posedge clock) disable iff (!rst_sync_n)
      (up && cnt[i] == CNT_MAX && !clear && !sw) |=> (cnt[i] == CNT_ZERO) && flag[i][ST_OV];
    endproperty
    a_ovf: assert property (p_ovf)
      else $error("overflow did not wrap to zero with flag");

    property p_unf;
      @(posedge clock) disable iff (!rst_sync_n)
      (dn && cnt[i] == CNT_ZERO && !clear && !sw) |=> (cnt[i] == CNT_MAX) && flag[i][ST_UN];
    endproperty
    a_unf: assert property (p_unf)
      else $error("underflow did not wrap with flag");

    property p_casc;
      @(posedge clock) disable iff (!rst_sync_n)
      (casc && !ov_ev[LO] && !un_ev[LO] && !clear && !sw) |=> $stable(cnt[i]);
    endproperty
    a_casc: assert property (p_casc)
      else $error("cascaded upper moved without lower wrap");

    property p_dir;
      @(posedge clock) disable iff (!rst_sync_n)
      (up || dn) |=> dir[i] == $past(up);
    endproperty
    a_dir: assert property (p_dir)
      else $error("direction flag wrong after count");

    property p_irq;
      @(posedge clock) disable iff (!rst_sync_n)
      (ov_ev[i] && ien[i][ST_OV] && !sw) |=> irq_req[i];
    endproperty
    a_irq: assert property (p_irq)
      else $error("enabled overflow raised no request");

    property p_pwm1_same;
      @(posedge clock) disable iff (!rst_sync_n)
      (start[i] && ctrl[i].mode == MODE_PWM1 && gr[i][0] == gr[i][1] && !sw) |=> $stable(pin_lvl[i][0]);
    endproperty
    a_pwm1_same: assert property (p_pwm1_same)
      else $error("pwm1 output changed with equal pair");
  end
endmodule
